// *** logic/pwr_seq_pkg.sv ***
package pwr_seq_pkg;

  // Clock rate and the long timing figures, each as a time and a derived cycle count.
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned RESET_HOLD_MS = 50;
  localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * 1000000 / CLK_PERIOD_NS;

  // Length of the internal baseband reset interval after regulators come up.
  localparam int unsigned BB_RESET_CYC = 64;

  // Number of internal regulators, and the one that feeds the backup domain.
  localparam int unsigned NUM_REG = 4;
  localparam int unsigned BACKUP_REG = 0;

  // Step timer end count; regulator steps of the on or off sequence come REG_STEP_CYC + 1 cycles apart.
  localparam int unsigned REG_STEP_CYC = 16;

  // Width of the general timing counter.
  localparam int unsigned CNT_W = 24;

  // Sequencer states, one-hot.
  typedef enum logic [9:0] {
    ST_OFF      = 10'h001,
    ST_REG_ON   = 10'h002,
    ST_BB_RST   = 10'h004,
    ST_CONFIG   = 10'h008,
    ST_RUN      = 10'h010,
    ST_SAVE     = 10'h020,
    ST_REG_OFF  = 10'h040,
    ST_UV_OFF   = 10'h080,
    ST_HW_RST   = 10'h100,
    ST_NOPWR    = 10'h200
  } seq_state_e;

endpackage

// *** logic/reset_low_filter.sv ***
`timescale 1ns/10ps
`default_nettype none

// Qualifies the external reset line: it reports a held reset only once the
// line has stayed low for the full hold time, so short glitches are ignored.
module reset_low_filter
  import pwr_seq_pkg::*;
#(
  parameter int unsigned HOLD_CYC = RESET_HOLD_CYC
)
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Raw line and qualified result.
  input wire logic line_low_b_i,
  output logic held_o
);

  logic [CNT_W-1:0] low_cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Count consecutive low cycles; any high cycle restarts the count.
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      low_cnt_q <= '0;
    end
    else if (line_low_b_i)
    begin
      low_cnt_q <= '0;
    end
    else if (low_cnt_q != CNT_W'(HOLD_CYC))
    begin
      low_cnt_q <= low_cnt_q + CNT_W'(1);
    end
  end

  // Held stays asserted while the line remains low after qualifying.
  assign held_o = (low_cnt_q == CNT_W'(HOLD_CYC));

endmodule

`default_nettype wire

// *** logic/module_power_sequencer.sv ***
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Power-off command: OK, save, detach, tristate.
// - Then regulators off in order, backup kept.
// - Stay off until switch-on fall, alarm or reset release.
// - Off state goes unpowered when supply lost.
// - Supply loss: shut down without save/detach.
// - Reset held 50 ms: full reset, tristate.
// - Hardware reset keeps backup/RTC, no save.
// - Function reset: baseband only, pins reset state.
// - Reset release starts power-on automatically.
// - Software reset re-enters baseband reset after save/detach.
// - Wake: tristate until regulators on, then reset.
module module_power_sequencer
  import pwr_seq_pkg::*;
#(
  parameter int unsigned HOLD_CYC = RESET_HOLD_CYC
)
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Supply and wake sources.
  input wire logic main_supply_ok_i,
  input wire logic switch_on_input_i,
  input wire logic rtc_alarm_i,
  input wire logic external_reset_low_input_b_i,
  // Commands from the command interface, one-cycle pulses.
  input wire logic power_off_command_i,
  input wire logic function_reset_command_i,
  // Housekeeping handshakes from the baseband.
  input wire logic save_done_i,
  input wire logic detach_done_i,
  // Command acknowledge and housekeeping requests.
  output logic cmd_ok_o,
  output logic save_req_o,
  output logic detach_req_o,
  // Power and reset controls.
  output logic [NUM_REG-1:0] reg_en_o,
  output logic interface_supply_en_o,
  output logic rtc_backup_supply_en_o,
  output logic baseband_reset_b_o,
  output logic pmu_reset_b_o,
  // Digital pin state.
  output logic pins_tristate_o,
  output logic pins_reset_state_o,
  output logic ready_o
);

  seq_state_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [NUM_REG-1:0] reg_en_q;
  logic sw_reset_q;
  logic save_seen_q;
  logic detach_seen_q;
  logic sw_on_prev_q;
  logic cmd_ok_q;
  logic hw_held;
  logic hw_held_prev_q;
  logic wake;
  logic step_due;
  logic regs_all_on;
  logic regs_all_off;

  ////////////////////////////////////////////////////////////////////////////
  // Reset line qualifier.
  reset_low_filter #(
    .HOLD_CYC(HOLD_CYC)
  ) u_rst_filter (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .line_low_b_i(external_reset_low_input_b_i),
    .held_o(hw_held)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wake decode and regulator step pacing.
  assign wake = (sw_on_prev_q && !switch_on_input_i) || rtc_alarm_i;
  assign step_due = (cnt_q == CNT_W'(REG_STEP_CYC));
  assign regs_all_on = &reg_en_q;
  assign regs_all_off = (reg_en_q == NUM_REG'(1 << BACKUP_REG));

  // Remember the switch-on line for falling edge detection.
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sw_on_prev_q <= 1'b1;
      hw_held_prev_q <= 1'b0;
    end
    else
    begin
      sw_on_prev_q <= switch_on_input_i;
      hw_held_prev_q <= hw_held;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequencer. Hardware reset and supply loss override everything.
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= ST_OFF;
      cnt_q <= '0;
      sw_reset_q <= 1'b0;
    end
    else if (!main_supply_ok_i)
    begin
      // Supply loss skips save and detach entirely.
      cnt_q <= '0;
      sw_reset_q <= 1'b0;
      if (state_q == ST_OFF || state_q == ST_NOPWR)
      begin
        state_q <= ST_NOPWR;
      end
      else
      begin
        state_q <= ST_UV_OFF;
      end
    end
    else if (hw_held)
    begin
      state_q <= ST_HW_RST;
      cnt_q <= '0;
      sw_reset_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_OFF:
        begin
          cnt_q <= '0;
          if (wake)
          begin
            state_q <= ST_REG_ON;
          end
        end
        ST_NOPWR, ST_UV_OFF:
        begin
          // Only a fresh supply brings the module back from here.
          state_q <= ST_REG_ON;
          cnt_q <= '0;
        end
        ST_HW_RST:
        begin
          cnt_q <= '0;
          if (hw_held_prev_q)
          begin
            state_q <= ST_REG_ON;
          end
        end
        ST_REG_ON:
        begin
          cnt_q <= step_due ? '0 : cnt_q + CNT_W'(1);
          if (regs_all_on)
          begin
            state_q <= ST_BB_RST;
            cnt_q <= '0;
          end
        end
        ST_BB_RST:
        begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (cnt_q == CNT_W'(BB_RESET_CYC - 1))
          begin
            state_q <= ST_CONFIG;
            cnt_q <= '0;
          end
        end
        ST_CONFIG:
        begin
          state_q <= ST_RUN;
        end
        ST_RUN:
        begin
          if (power_off_command_i)
          begin
            state_q <= ST_SAVE;
            sw_reset_q <= 1'b0;
          end
          else if (function_reset_command_i)
          begin
            state_q <= ST_SAVE;
            sw_reset_q <= 1'b1;
          end
        end
        ST_SAVE:
        begin
          cnt_q <= '0;
          if (save_seen_q && detach_seen_q)
          begin
            if (sw_reset_q)
            begin
              state_q <= ST_BB_RST;
              sw_reset_q <= 1'b0;
            end
            else
            begin
              state_q <= ST_REG_OFF;
            end
          end
        end
        ST_REG_OFF:
        begin
          cnt_q <= step_due ? '0 : cnt_q + CNT_W'(1);
          if (regs_all_off)
          begin
            state_q <= ST_OFF;
          end
        end
        default:
        begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Save and detach completion, captured while in the save phase.
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      save_seen_q <= 1'b0;
      detach_seen_q <= 1'b0;
    end
    else if (state_q != ST_SAVE)
    begin
      save_seen_q <= 1'b0;
      detach_seen_q <= 1'b0;
    end
    else
    begin
      save_seen_q <= save_seen_q | save_done_i;
      detach_seen_q <= detach_seen_q | detach_done_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Regulator enables: one step up from bit 0 on the way in, one step down
  // from the top on the way out. The backup regulator is never dropped.
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      reg_en_q <= NUM_REG'(1 << BACKUP_REG);
    end
    else if (!main_supply_ok_i || hw_held)
    begin
      reg_en_q <= NUM_REG'(1 << BACKUP_REG);
    end
    else if (state_q == ST_REG_ON && step_due)
    begin
      reg_en_q <= NUM_REG'({reg_en_q, 1'b1});
    end
    else if (state_q == ST_REG_OFF && step_due)
    begin
      reg_en_q <= (reg_en_q >> 1) | NUM_REG'(1 << BACKUP_REG);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // OK answer, one cycle after the power-off command is taken.
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cmd_ok_q <= 1'b0;
    end
    else
    begin
      cmd_ok_q <= (state_q == ST_RUN) && power_off_command_i && main_supply_ok_i && !hw_held;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs decoded from state. The backup supply is on for any reset.
  assign cmd_ok_o = cmd_ok_q;
  assign save_req_o = (state_q == ST_SAVE) && !save_seen_q;
  assign detach_req_o = (state_q == ST_SAVE) && !detach_seen_q;
  assign reg_en_o = reg_en_q;
  assign rtc_backup_supply_en_o = 1'b1;
  assign interface_supply_en_o = (state_q == ST_BB_RST) || (state_q == ST_CONFIG) ||
                                 (state_q == ST_RUN) || (state_q == ST_SAVE);
  assign baseband_reset_b_o = (state_q == ST_CONFIG) || (state_q == ST_RUN) ||
                              (state_q == ST_SAVE);
  assign pmu_reset_b_o = (state_q != ST_HW_RST);
  // Pins float except while the baseband is up (outside a power-off save) or held in its own reset.
  assign pins_tristate_o = !interface_supply_en_o || (state_q == ST_SAVE && !sw_reset_q);
  assign pins_reset_state_o = (state_q == ST_BB_RST);
  assign ready_o = (state_q == ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  ok_after_cmd_a: assert property ((state_q == ST_RUN && power_off_command_i && main_supply_ok_i && !hw_held) |=> cmd_ok_o) else $error("no OK after power-off");
  off_tristate_a: assert property ((state_q == ST_OFF) |-> pins_tristate_o && reg_en_o == NUM_REG'(1 << BACKUP_REG)) else $error("off state not isolated");
  off_stays_a: assert property ((state_q == ST_OFF && !wake && main_supply_ok_i && !hw_held) |=> state_q == ST_OFF) else $error("left off without wake");
  nopwr_entry_a: assert property ((state_q == ST_OFF && !main_supply_ok_i) |=> state_q == ST_NOPWR) else $error("no not-powered entry");
  uv_nosave_a: assert property ((state_q == ST_RUN && !main_supply_ok_i) |=> !save_req_o && !detach_req_o) else $error("save on supply loss");
  hw_rst_a: assert property ((hw_held && main_supply_ok_i) |=> state_q == ST_HW_RST && !interface_supply_en_o && pins_tristate_o) else $error("hardware reset not applied");
  backup_kept_a: assert property (rtc_backup_supply_en_o && reg_en_o[BACKUP_REG]) else $error("backup domain dropped");
  fn_rst_a: assert property ((state_q == ST_RUN && function_reset_command_i && !power_off_command_i && main_supply_ok_i && !hw_held) |=> save_req_o && interface_supply_en_o && pmu_reset_b_o) else $error("function reset wrong");
  hw_release_a: assert property ((state_q == ST_HW_RST && !hw_held && main_supply_ok_i) |=> state_q == ST_REG_ON) else $error("no power-on after release");
  bb_hold_a: assert property ($rose(state_q == ST_BB_RST) |-> (!baseband_reset_b_o)[*8]) else $error("baseband reset too short");
  short_pulse_a: assert property ($rose(!external_reset_low_input_b_i) ##1 external_reset_low_input_b_i |-> !hw_held) else $error("short pulse qualified");

  pwroff_c: cover property (state_q == ST_REG_OFF ##[1:200] state_q == ST_OFF);
  swrst_c: cover property (state_q == ST_SAVE && sw_reset_q ##[1:200] state_q == ST_BB_RST);
  wake_c: cover property (state_q == ST_OFF ##1 state_q == ST_REG_ON);
  hwrst_c: cover property (state_q == ST_HW_RST ##1 state_q == ST_REG_ON);

endmodule

`default_nettype wire

// *** verification/host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// Host side of the sequencer: a push button on the reset line, and the
// baseband housekeeping that answers save and detach requests.
module host_model
#(
  parameter int unsigned SAVE_DLY = 3,
  parameter int unsigned DETACH_DLY = 40
)
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Button control from the bench.
  input wire logic press_go_i,
  input wire logic [7:0] press_len_i,
  // Housekeeping handshake.
  input wire logic save_req_i,
  input wire logic detach_req_i,
  output logic save_done_o,
  output logic detach_done_o,
  // Reset line, pulled up when the button is released.
  output logic reset_line_b_o
);
  logic [7:0] press_q;
  logic [7:0] save_cnt_q;
  logic [7:0] det_cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Button holds the line low for the commanded count; the length decides
  // whether the hold is long enough.
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      press_q <= 8'h00;
    else if (press_go_i)
      press_q <= press_len_i;
    else if (press_q != 8'h00)
      press_q <= press_q - 8'h01;
  end

  assign reset_line_b_o = (press_q == 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Save finishes promptly, detach slowly, as a real network would.
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      save_cnt_q <= 8'h00;
      save_done_o <= 1'b0;
    end
    else
    begin
      save_done_o <= save_req_i && !save_done_o && (save_cnt_q == 8'(SAVE_DLY));
      save_cnt_q <= save_req_i ? save_cnt_q + 8'h01 : 8'h00;
    end
  end

  // Detach answer, one-cycle pulse after its delay.
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      det_cnt_q <= 8'h00;
      detach_done_o <= 1'b0;
    end
    else
    begin
      detach_done_o <= detach_req_i && !detach_done_o && (det_cnt_q == 8'(DETACH_DLY));
      det_cnt_q <= detach_req_i ? det_cnt_q + 8'h01 : 8'h00;
    end
  end
endmodule

`default_nettype wire

// *** verification/module_power_off_and_reset_control_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module module_power_off_and_reset_control_tb
  import pwr_seq_pkg::*;
;
  logic clk, rst_b, supply, sw_on, alarm, rline, pwr_cmd, fn_cmd, sdone, ddone, go;
  logic [7:0] plen;
  logic cmd_ok, sreq, dreq, ifs, bck, bb_rst_b, pmu_b, tri_st, pin_rst, ready;
  logic [NUM_REG-1:0] reg_en;
  int fail_count = 0;
  int comparisons = 0;

  module_power_sequencer #(.HOLD_CYC(20)) i_module_power_sequencer (
    .sys_clk_i(clk), .rst_b_i(rst_b), .main_supply_ok_i(supply),
    .switch_on_input_i(sw_on), .rtc_alarm_i(alarm),
    .external_reset_low_input_b_i(rline), .power_off_command_i(pwr_cmd),
    .function_reset_command_i(fn_cmd), .save_done_i(sdone), .detach_done_i(ddone),
    .cmd_ok_o(cmd_ok), .save_req_o(sreq), .detach_req_o(dreq), .reg_en_o(reg_en),
    .interface_supply_en_o(ifs), .rtc_backup_supply_en_o(bck),
    .baseband_reset_b_o(bb_rst_b), .pmu_reset_b_o(pmu_b),
    .pins_tristate_o(tri_st), .pins_reset_state_o(pin_rst), .ready_o(ready));

  host_model i_host_model (
    .sys_clk_i(clk), .rst_b_i(rst_b), .press_go_i(go), .press_len_i(plen),
    .save_req_i(sreq), .detach_req_i(dreq), .save_done_o(sdone),
    .detach_done_o(ddone), .reset_line_b_o(rline));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 250 MHz.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Shared comparison; case inequality so an unknown never matches.
  // Wide enough for the packed groups that the scenarios compare in one go.
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  // Bounded wait for the run state.
  task automatic wait_ready();
    int n;
    for (n = 0; n < 400 && ready !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    check(ready, 1'b1, "ready");
    check(tri_st, 1'b0, "pins driven in run");
    check(bb_rst_b, 1'b1, "baseband out of reset");
  endtask

  // Follows the regulator walk one step at a time, up or down.
  task automatic watch_regs(input bit up);
    logic [3:0] prev;
    int n;
    prev = reg_en;
    for (n = 0; n < 200 && reg_en !== (up ? 4'hF : 4'h1); n++)
    begin
      @(posedge clk);
      #1;
      if (reg_en !== prev)
      begin
        check(reg_en, up ? {prev[2:0], 1'b1} : ({1'b0, prev[3:1]} | 4'h1), "step");
        prev = reg_en;
      end
      if (up && reg_en !== 4'hF)
        check(tri_st, 1'b1, "pins float while rising");
      check(bck, 1'b1, "backup supply");
    end
  endtask

  // One-cycle command pulse, then its immediate answer.
  task automatic send_cmd(input bit pwr);
    @(posedge clk);
    pwr_cmd <= pwr;
    fn_cmd <= !pwr;
    @(posedge clk);
    pwr_cmd <= 1'b0;
    fn_cmd <= 1'b0;
    #1;
    check(cmd_ok, pwr, "ok answer only for power-off");
    check({sreq, dreq}, 2'b11, "save and detach requested");
    check(tri_st, pwr, "pin float on command");
    @(posedge clk);
    #1;
    check(cmd_ok, 1'b0, "ok lasts one cycle");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic wake(input bit by_alarm);
    @(posedge clk);
    sw_on <= by_alarm;
    alarm <= by_alarm;
    @(posedge clk);
    sw_on <= 1'b1;
    alarm <= 1'b0;
    watch_regs(1'b1);
    repeat (2) @(posedge clk);
    #1;
    check(bb_rst_b, 1'b0, "baseband held in reset");
    wait_ready();
  endtask

  task automatic power_off();
    send_cmd(1'b1);
    watch_regs(1'b0);
    repeat (40) @(posedge clk);
    #1;
    check({ready, tri_st, reg_en}, 6'h11, "stays off");
    send_cmd_refused();
  endtask

  // A command outside run is ignored.
  task automatic send_cmd_refused();
    @(posedge clk);
    fn_cmd <= 1'b1;
    @(posedge clk);
    fn_cmd <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({cmd_ok, sreq, ready}, 3'b000, "command refused when off");
  endtask

  task automatic function_reset();
    int n;
    send_cmd(1'b0);
    for (n = 0; n < 200 && pin_rst !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    check({sreq, dreq, bb_rst_b}, 3'b000, "reset after housekeeping");
    check({ifs, pmu_b, reg_en}, 6'h3F, "supply and power kept");
    wait_ready();
  endtask

  task automatic hw_reset(input logic [7:0] len);
    @(posedge clk);
    go <= 1'b1;
    plen <= len;
    @(posedge clk);
    go <= 1'b0;
    repeat (len - 2) @(posedge clk);
    #1;
    if (len > 8'd20)
      check({pmu_b, ifs, tri_st, sreq, bck, reg_en}, 9'h051, "hardware reset");
    else
      check({ready, pmu_b}, 2'b11, "short pulse ignored");
    wait_ready();
  endtask

  task automatic supply_loss(input bit from_off);
    @(posedge clk);
    supply <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check({sreq, dreq, ready, tri_st, bck}, 5'h03, "no save on supply loss");
    @(posedge clk);
    supply <= 1'b1;
    if (!from_off)
      wait_ready();
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    {rst_b, pwr_cmd, fn_cmd, alarm, go} = 5'h00;
    {supply, sw_on} = 2'b11;
    plen = 8'h00;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    wake(1'b0);
    power_off();
    wake(1'b1);
    function_reset();
    hw_reset(8'd10);
    hw_reset(8'd30);
    supply_loss(1'b0);
    power_off();
    supply_loss(1'b1);
    wait_ready();
    final_report();
  end

  // Watchdog well beyond the expected length of the run.
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end
endmodule

`default_nettype wire
